// ===== design/smc_consts.svh
// Constants for the sleep-mode controller: register offsets, field positions,
// reset values and timing counts. Included by the design file only.
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// Register offsets (3-bit word address)
`define SMC_ADDR_CTRL 3'h0
`define SMC_ADDR_ACMP 3'h1
`define SMC_ADDR_ASYNC 3'h2
`define SMC_ADDR_TMSK 3'h3
`define SMC_ADDR_STAT 3'h4

// Field positions
`define SMC_SE_BIT 5
`define SMC_SM_HI 4
`define SMC_SM_LO 3
`define SMC_ACD_BIT 7
`define SMC_AS0_BIT 3
`define SMC_MSK_CMP 1
`define SMC_MSK_OVF 0

// Mode select encodings
`define SMC_MODE_IDLE 2'h0
`define SMC_MODE_RSVD 2'h1
`define SMC_MODE_PDOWN 2'h2
`define SMC_MODE_PSAVE 2'h3

// Reset values
`define SMC_RST_BYTE 8'h00
`define SMC_RST_CNT 16'h0000

// Timing
`define SMC_CLK_PERIOD_NS 10
`define SMC_WDT_PERIOD_NS 1000
`define SMC_WDT_CYC (`SMC_WDT_PERIOD_NS / `SMC_CLK_PERIOD_NS)
`define SMC_POST_EXT_CYC 2
`define SMC_POST_TMR_CYC 3
`define SMC_LVL_SAMPLES 2

`endif

// ===== design/smc_pkg.sv
// Types shared by the sleep-mode controller.
// Needs no other file; the design imports it whole.
package smc_pkg;
  typedef enum logic [2:0] {
    smc_st_active,
    smc_st_idle,
    smc_st_pdown,
    smc_st_restart,
    smc_st_postwake
  } smc_state_type;

  typedef enum logic [2:0] {
    smc_cause_none,
    smc_cause_irq,
    smc_cause_level,
    smc_cause_timer,
    smc_cause_wdt
  } smc_cause_type;
endpackage

// ===== design/smc_sleep_ctrl.sv
// Sleep-mode controller: takes the sleep instruction, enters Idle, Power-down
// or Power Save, qualifies wake sources and times the restart.
// Assumes the CPU, interrupt system and watchdog share sys_clk_i; the level
// interrupt pin and the timer0 event toggles arrive from other domains.
//
// Notes on behaviour
// - Sleep only when sleep_enable set at instruction.
// - Select 00 enters Idle.
// - Select 10 enters Power-down.
// - Select 11 enters Power Save.
// - Enabled interrupt wakes, routine then resumes.
// - Sleep leaves registers and memories untouched.
// - Reset while asleep restarts at reset vector.
// - Idle halts only the CPU.
// - Idle wake resumes with no delay.
// - Power-down stops oscillator, keeps interrupts, watchdog.
// - Power-down wakes on reset, watchdog, level.
// - Level sampled twice on watchdog tick.
// - Power-down wake waits fuse-selected restart delay.
// - Vanished wake condition runs no interrupt.
// - Power Save keeps async timer0 counting.
// - Power Save also wakes on enabled timer0 events.
// - Timer wake routine needs global interrupt enable.
// - External wake in Power Save: two cycles before flag update.
// - Timer wake: three cycles before flag update.
// - Post-wake cycles run code, flags held.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "smc_consts.svh"

module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter logic [15:0] DLY_SEL0 = 16'h0010,
  parameter logic [15:0] DLY_SEL1 = 16'h0040,
  parameter logic [15:0] DLY_SEL2 = 16'h0100,
  parameter logic [15:0] DLY_SEL3 = 16'h0400
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [7:0] rd_data_o,
  input wire logic sleep_instr_i,
  input wire logic irq_pending_i,
  input wire logic global_irq_en_i,
  input wire logic wdt_reset_i,
  input wire logic ext_level_irq_n_i,
  input wire logic t0_ovf_tgl_i,
  input wire logic t0_cmp_tgl_i,
  input wire logic [1:0] startup_time_fuses_i,
  output logic cpu_halt_o,
  output logic osc_stop_o,
  output logic comparator_off_o,
  output logic timer0_run_o,
  output logic wake_irq_o,
  output logic flag_hold_o,
  output logic reset_req_o
);

  // ==========================================================
  // State
  typedef struct packed {
    smc_state_type st;
    smc_cause_type cause;
    logic ps;
    logic [15:0] cnt;
    logic [1:0] post_cnt;
    logic sleep_enable;
    logic [1:0] sleep_mode_select;
    logic comparator_disable;
    logic timer0_async_select;
    logic [1:0] timer_irq_mask;
    logic lvl_s1;
    logic lvl_s2;
    logic ovf_s1;
    logic ovf_s2;
    logic ovf_d;
    logic cmp_s1;
    logic cmp_s2;
    logic cmp_d;
    logic [6:0] wdt_div;
    logic [1:0] lvl_hits;
    logic [7:0] rd_data;
    logic cpu_halt;
    logic osc_stop;
    logic acmp_off;
    logic t0_run;
    logic wake_irq;
    logic flag_hold;
    logic reset_req;
  } smc_regs_type;

  smc_regs_type r;
  smc_regs_type n;

  // Restart delay per fuse setting; the oscillator needs this to settle
  function automatic logic [15:0] restart_cycles(input logic [1:0] sel);
    if (sel == 2'h0) begin
      restart_cycles = DLY_SEL0;
    end else if (sel == 2'h1) begin
      restart_cycles = DLY_SEL1;
    end else if (sel == 2'h2) begin
      restart_cycles = DLY_SEL2;
    end else begin
      restart_cycles = DLY_SEL3;
    end
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic wdt_tick;
    logic lvl_ok;
    logic tmr_wake;
    wdt_tick = 1'b0;
    lvl_ok = 1'b0;
    tmr_wake = 1'b0;
    n = r;
    // Synchronisers for pins and foreign-domain toggles
    n.lvl_s1 = ext_level_irq_n_i;
    n.lvl_s2 = r.lvl_s1;
    n.ovf_s1 = t0_ovf_tgl_i;
    n.ovf_s2 = r.ovf_s1;
    n.ovf_d = r.ovf_s2;
    n.cmp_s1 = t0_cmp_tgl_i;
    n.cmp_s2 = r.cmp_s1;
    n.cmp_d = r.cmp_s2;
    n.rd_data = `SMC_RST_BYTE;
    n.wake_irq = 1'b0;
    n.reset_req = 1'b0;

    // Register reads: data valid only in the following cycle
    if (rd_en_i) begin
      if (addr_i == `SMC_ADDR_CTRL) begin
        n.rd_data[`SMC_SE_BIT] = r.sleep_enable;
        n.rd_data[`SMC_SM_HI:`SMC_SM_LO] = r.sleep_mode_select;
      end else if (addr_i == `SMC_ADDR_ACMP) begin
        n.rd_data[`SMC_ACD_BIT] = r.comparator_disable;
      end else if (addr_i == `SMC_ADDR_ASYNC) begin
        n.rd_data[`SMC_AS0_BIT] = r.timer0_async_select;
      end else if (addr_i == `SMC_ADDR_TMSK) begin
        n.rd_data[1:0] = r.timer_irq_mask;
      end else if (addr_i == `SMC_ADDR_STAT) begin
        n.rd_data = {2'h0, r.cause, r.st};
      end
    end

    // Register writes; unmapped offsets are ignored
    if (wr_en_i) begin
      if (addr_i == `SMC_ADDR_CTRL) begin
        n.sleep_enable = wr_data_i[`SMC_SE_BIT];
        n.sleep_mode_select = wr_data_i[`SMC_SM_HI:`SMC_SM_LO];
      end else if (addr_i == `SMC_ADDR_ACMP) begin
        n.comparator_disable = wr_data_i[`SMC_ACD_BIT];
      end else if (addr_i == `SMC_ADDR_ASYNC) begin
        n.timer0_async_select = wr_data_i[`SMC_AS0_BIT];
      end else if (addr_i == `SMC_ADDR_TMSK) begin
        n.timer_irq_mask = wr_data_i[1:0];
      end
    end

    // Nominal watchdog oscillator tick, free running
    wdt_tick = (r.wdt_div == 7'(`SMC_WDT_CYC - 1));
    n.wdt_div = wdt_tick ? 7'h00 : r.wdt_div + 7'h01;

    // A lone low sample never wakes the part, so a glitch on the pin cannot
    // start the oscillator; the price is a wake-up of up to two ticks
    // Level must stay low across two ticks; any high sample restarts it
    if (r.st != smc_st_pdown || r.lvl_s2) begin
      n.lvl_hits = 2'h0;
    end else if (wdt_tick && r.lvl_hits != 2'(`SMC_LVL_SAMPLES)) begin
      n.lvl_hits = r.lvl_hits + 2'h1;
    end
    lvl_ok = (r.lvl_hits == 2'(`SMC_LVL_SAMPLES)) && !r.lvl_s2;

    // Timer events count only in Power Save with async clocking
    tmr_wake = r.ps && r.timer0_async_select &&
               (((r.ovf_s2 ^ r.ovf_d) && r.timer_irq_mask[`SMC_MSK_OVF]) ||
                ((r.cmp_s2 ^ r.cmp_d) && r.timer_irq_mask[`SMC_MSK_CMP]));

    // Sleep sequence
    case (r.st)
      smc_st_active: begin
        // Clear sleep_enable or reserved select leaves the CPU running
        if (sleep_instr_i && r.sleep_enable) begin
          if (r.sleep_mode_select == `SMC_MODE_IDLE) begin
            n.st = smc_st_idle;
          end else if (r.sleep_mode_select == `SMC_MODE_PDOWN) begin
            n.st = smc_st_pdown;
            n.ps = 1'b0;
          end else if (r.sleep_mode_select == `SMC_MODE_PSAVE) begin
            n.st = smc_st_pdown;
            n.ps = 1'b1;
          end
        end
      end
      smc_st_idle: begin
        // Peripherals run on; any enabled interrupt wakes at once
        if (wdt_reset_i) begin
          n.st = smc_st_active;
          n.cause = smc_cause_wdt;
          n.reset_req = 1'b1;
        end else if (irq_pending_i) begin
          n.st = smc_st_active;
          n.cause = smc_cause_irq;
          n.wake_irq = 1'b1;
        end
      end
      smc_st_pdown: begin
        // Only watchdog reset, qualified level, or Power Save timer event
        if (wdt_reset_i) begin
          n.cause = smc_cause_wdt;
        end else if (lvl_ok) begin
          n.cause = smc_cause_level;
        end else if (tmr_wake) begin
          n.cause = smc_cause_timer;
        end
        if (wdt_reset_i || lvl_ok || tmr_wake) begin
          n.st = smc_st_restart;
          n.cnt = restart_cycles(startup_time_fuses_i) - 16'h0001;
        end
      end
      smc_st_restart: begin
        if (r.cnt != `SMC_RST_CNT) begin
          n.cnt = r.cnt - 16'h0001;
        end else if (r.cause == smc_cause_wdt) begin
          n.st = smc_st_active;
          n.reset_req = 1'b1;
        end else if (r.cause == smc_cause_timer) begin
          n.st = smc_st_postwake;
          n.post_cnt = 2'(`SMC_POST_TMR_CYC - 1);
        end else if (r.lvl_s2) begin
          n.st = smc_st_active;
        end else if (r.ps) begin
          n.st = smc_st_postwake;
          n.post_cnt = 2'(`SMC_POST_EXT_CYC - 1);
        end else begin
          n.st = smc_st_active;
          n.wake_irq = 1'b1;
        end
      end
      smc_st_postwake: begin
        // CPU runs; interrupt flags held until the count ends
        if (r.post_cnt != 2'h0) begin
          n.post_cnt = r.post_cnt - 2'h1;
        end else begin
          n.st = smc_st_active;
          n.wake_irq = (r.cause == smc_cause_timer) ? global_irq_en_i : 1'b1;
        end
      end
      default: begin
        n.st = smc_st_active;
      end
    endcase

    // Outputs follow the next state so they line up with it
    n.cpu_halt = (n.st == smc_st_idle) || (n.st == smc_st_pdown) ||
                 (n.st == smc_st_restart);
    n.osc_stop = (n.st == smc_st_pdown);
    n.acmp_off = n.comparator_disable;
    n.t0_run = (n.st != smc_st_pdown) || (n.ps && n.timer0_async_select);
    n.flag_hold = (n.st == smc_st_postwake);
  end

  // ==========================================================
  // State register; clock gating only, so the CPU keeps all contents
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else if (clk_en_i) begin
      r <= n;
    end
  end

  // Outputs come straight from the state register, no logic after the flops
  assign rd_data_o = r.rd_data;
  assign cpu_halt_o = r.cpu_halt;
  assign osc_stop_o = r.osc_stop;
  assign comparator_off_o = r.acmp_off;
  assign timer0_run_o = r.t0_run;
  assign wake_irq_o = r.wake_irq;
  assign flag_hold_o = r.flag_hold;
  assign reset_req_o = r.reset_req;

  // ==========================================================
  // Assertions
  default clocking smc_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  no_sleep_a: assert property (clk_en_i && r.st == smc_st_active && sleep_instr_i && !r.sleep_enable
    |=> r.st == smc_st_active && !cpu_halt_o) else $error("sleep entered with enable clear");
  idle_entry_a: assert property (clk_en_i && r.st == smc_st_active && sleep_instr_i && r.sleep_enable
    && r.sleep_mode_select == `SMC_MODE_IDLE |=> r.st == smc_st_idle && cpu_halt_o && !osc_stop_o)
    else $error("idle not entered");
  pd_entry_a: assert property (clk_en_i && r.st == smc_st_active && sleep_instr_i && r.sleep_enable
    && r.sleep_mode_select == `SMC_MODE_PDOWN |=> r.st == smc_st_pdown && !r.ps && osc_stop_o)
    else $error("power-down not entered");
  ps_entry_a: assert property (clk_en_i && r.st == smc_st_active && sleep_instr_i && r.sleep_enable
    && r.sleep_mode_select == `SMC_MODE_PSAVE |=> r.st == smc_st_pdown && r.ps)
    else $error("power save not entered");
  rsvd_mode_a: assert property (clk_en_i && r.st == smc_st_active && sleep_instr_i
    && r.sleep_mode_select == `SMC_MODE_RSVD |=> r.st == smc_st_active) else $error("reserved mode slept");
  idle_wake_a: assert property (clk_en_i && r.st == smc_st_idle && irq_pending_i && !wdt_reset_i
    |=> !cpu_halt_o && wake_irq_o) else $error("idle wake delayed");
  timer_run_a: assert property (r.st == smc_st_pdown |-> timer0_run_o == (r.ps && r.timer0_async_select))
    else $error("timer0 run wrong in sleep");
  post_hold_a: assert property (r.st == smc_st_postwake |-> flag_hold_o && !cpu_halt_o && !wake_irq_o)
    else $error("post-wake flags not held");
  level_gone_a: assert property (clk_en_i && r.st == smc_st_restart && r.cnt == 16'h0000
    && r.cause == smc_cause_level && r.lvl_s2 |=> r.st == smc_st_active && !wake_irq_o)
    else $error("vanished level ran interrupt");
  tmr_post_a: assert property (clk_en_i && r.st == smc_st_restart && r.cnt == 16'h0000
    && r.cause == smc_cause_timer |=> r.st == smc_st_postwake && r.post_cnt == 2'h2)
    else $error("timer post-wake count wrong");

  // Later sleep phases: sleeping outputs, wake sources and post-wake gating
  idle_run_a: assert property (r.st == smc_st_idle |-> cpu_halt_o && !osc_stop_o && timer0_run_o)
    else $error("idle halted more than the CPU");
  pd_hold_a: assert property (r.st == smc_st_pdown |-> cpu_halt_o && osc_stop_o)
    else $error("power-down outputs wrong");
  pd_sources_a: assert property (clk_en_i && r.st == smc_st_pdown && !r.ps && !wdt_reset_i
    && r.lvl_hits != 2'(`SMC_LVL_SAMPLES) |=> r.st == smc_st_pdown)
    else $error("power-down woke without source");
  restart_halt_a: assert property (r.st == smc_st_restart |-> cpu_halt_o && !osc_stop_o)
    else $error("restart delay outputs wrong");
  wdt_restart_a: assert property (clk_en_i && r.st == smc_st_restart && r.cnt == 16'h0000
    && r.cause == smc_cause_wdt |=> reset_req_o && !cpu_halt_o && !wake_irq_o)
    else $error("watchdog wake missed reset");
  ext_post_a: assert property (clk_en_i && r.st == smc_st_restart && r.cnt == 16'h0000 && r.ps
    && r.cause == smc_cause_level && !r.lvl_s2 |=> r.st == smc_st_postwake && r.post_cnt == 2'h1)
    else $error("external post-wake count wrong");
  gie_gate_a: assert property (clk_en_i && r.st == smc_st_postwake && r.post_cnt == 2'h0
    && r.cause == smc_cause_timer |=> wake_irq_o == $past(global_irq_en_i))
    else $error("timer wake ignored interrupt enable");

endmodule // smc_sleep_ctrl

`default_nettype wire

// ===== dv/smc_wake_model.sv
// Wake-source model: level interrupt pin with pull-up and timer0 event toggles.
// Assumes the bench requests events one clock at a time on the system clock.
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Wake sources
module smc_wake_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic lvl_req_i,
  input wire logic ovf_ev_i,
  input wire logic cmp_ev_i,
  output logic lvl_n_o,
  output logic ovf_tgl_o,
  output logic cmp_tgl_o
);
  // Pin has a pull-up, so a released line reads high, never a stale value
  assign lvl_n_o = ~lvl_req_i;
  // Events cross as toggles; a pulse would be lost when sampled from another domain
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ovf_tgl_o <= 1'b0;
      cmp_tgl_o <= 1'b0;
    end else begin
      ovf_tgl_o <= ovf_tgl_o ^ ovf_ev_i;
      cmp_tgl_o <= cmp_tgl_o ^ cmp_ev_i;
    end
  end
endmodule // smc_wake_model
`default_nettype wire

// ===== dv/smc_tb.sv
// Self-checking bench for the sleep-mode controller.
// Assumes a 100 MHz clock and short restart delays set through DLY_SEL1 and DLY_SEL2.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [15:0] D = 16'h0028;
  localparam logic [15:0] D2 = 16'h0030;
  logic clk_en;
  logic [1:0] fuses;
  logic sys_clk, reset_n, wr_en, rd_en, sleep_in, irq_pend, gie, wdt_rst;
  logic lvl_n, ovf_tgl, cmp_tgl, lvl_req, ovf_ev, cmp_ev;
  logic halt, osc_stop, cmp_off, t0_run, wake_irq, flag_hold, reset_req;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  int failures, n_checks, cycles;
  // ==========================================
  // Design and wake sources
  smc_sleep_ctrl #(.DLY_SEL1(D), .DLY_SEL2(D2)) dut_u (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
    .clk_en_i(clk_en), .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rdata),
    .sleep_instr_i(sleep_in), .irq_pending_i(irq_pend), .global_irq_en_i(gie), .wdt_reset_i(wdt_rst),
    .ext_level_irq_n_i(lvl_n), .t0_ovf_tgl_i(ovf_tgl), .t0_cmp_tgl_i(cmp_tgl),
    .startup_time_fuses_i(fuses), .cpu_halt_o(halt), .osc_stop_o(osc_stop), .comparator_off_o(cmp_off),
    .timer0_run_o(t0_run), .wake_irq_o(wake_irq), .flag_hold_o(flag_hold), .reset_req_o(reset_req));
  smc_wake_model part_u (.clk_i(sys_clk), .reset_n_i(reset_n), .lvl_req_i(lvl_req), .ovf_ev_i(ovf_ev),
    .cmp_ev_i(cmp_ev), .lvl_n_o(lvl_n), .ovf_tgl_o(ovf_tgl), .cmp_tgl_o(cmp_tgl));
  // ==========================================
  // Clock and hang guard; ceiling is more than ten times the expected run
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      stop_test();
    end
  end
  // ==========================================
  // Shared tasks
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test();
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task tk();
    @(posedge sys_clk);
    #1;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk) begin wr_en <= 1'b1; addr <= a; wdata <= d; end
    @(posedge sys_clk) wr_en <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk) begin rd_en <= 1'b1; addr <= a; end
    @(posedge sys_clk) rd_en <= 1'b0;
    #1 chk("rd_data", rdata, exp);
  endtask
  // Sleep enable and select written as given, then one sleep instruction
  task sleep_go(input logic se, input logic [1:0] sm);
    wr(3'h0, {2'h0, se, sm, 3'h0});
    @(posedge sys_clk) sleep_in <= 1'b1;
    @(posedge sys_clk) sleep_in <= 1'b0;
    #1;
  endtask
  // Waits for the oscillator restart, times it, then judges the post-wake window
  task wake_seq(input int hold_exp, input logic irq_exp, input logic rst_exp, input logic keep);
    int d;
    int h;
    // Step off the edge first, or a wake on the calling edge is seen a cycle late
    #1;
    for (d = 0; d < 1000 && osc_stop === 1'b1; d++) tk();
    @(posedge sys_clk) lvl_req <= lvl_req & keep;
    #1 d = 1;
    while (halt === 1'b1 && d < 2000) begin d++; tk(); end
    chk("restart_len", d[15:0], (fuses == 2'h2) ? D2 : D);
    for (h = 0; flag_hold === 1'b1 && h < 10; h++) begin
      chk("post_halt", halt, 1'b0);
      chk("post_irq", wake_irq, 1'b0);
      tk();
    end
    chk("hold_len", h[15:0], hold_exp[15:0]);
    chk("wake_irq", wake_irq, irq_exp);
    chk("reset_req", reset_req, rst_exp);
    lvl_req <= 1'b0;
    repeat (5) tk();
  endtask
  // ==========================================
  // Scenarios
  task t_regs();
    for (int i = 0; i < 6; i++) rd(i[2:0], 8'h00);
    wr(3'h4, 8'hff);
    wr(3'h5, 8'hff);
    rd(3'h4, 8'h00);
    rd(3'h5, 8'h00);
  endtask
  task t_refused();
    sleep_go(1'b0, 2'h2);
    chk("halt_se0", halt, 1'b0);
    sleep_go(1'b1, 2'h1);
    tk();
    chk("halt_rsvd", halt | osc_stop, 1'b0);
  endtask
  task t_idle();
    wr(3'h1, 8'h80);
    tk();
    chk("cmp_off", cmp_off, 1'b1);
    sleep_go(1'b1, 2'h0);
    chk("idle_halt", {halt, osc_stop, t0_run}, 3'h5);
    // Clock enable low: an interrupt must not move the frozen state
    @(posedge sys_clk) begin clk_en <= 1'b0; irq_pend <= 1'b1; end
    @(posedge sys_clk) irq_pend <= 1'b0;
    @(posedge sys_clk) clk_en <= 1'b1;
    #1 chk("frozen", {halt, wake_irq}, 2'h2);
    @(posedge sys_clk) irq_pend <= 1'b1;
    @(posedge sys_clk) irq_pend <= 1'b0;
    #1 chk("idle_wake", {halt, wake_irq}, 2'h1);
    rd(3'h0, 8'h20);
    rd(3'h1, 8'h80);
    sleep_go(1'b1, 2'h0);
    @(posedge sys_clk) wdt_rst <= 1'b1;
    @(posedge sys_clk) wdt_rst <= 1'b0;
    #1 chk("idle_wdt", {halt, reset_req}, 2'h1);
  endtask
  task t_pdown();
    wr(3'h2, 8'h08);
    wr(3'h3, 8'h03);
    sleep_go(1'b1, 2'h2);
    chk("pd_state", {halt, osc_stop, t0_run}, 3'h6);
    @(posedge sys_clk) ovf_ev <= 1'b1;
    @(posedge sys_clk) begin ovf_ev <= 1'b0; lvl_req <= 1'b1; end
    repeat (50) tk();
    @(posedge sys_clk) lvl_req <= 1'b0;
    repeat (400) tk();
    chk("pd_no_wake", osc_stop, 1'b1);
    @(posedge sys_clk) lvl_req <= 1'b1;
    wake_seq(0, 1'b1, 1'b0, 1'b1);
    rd(3'h3, 8'h03);
    sleep_go(1'b1, 2'h2);
    @(posedge sys_clk) lvl_req <= 1'b1;
    wake_seq(0, 1'b0, 1'b0, 1'b0);
    @(posedge sys_clk) fuses <= 2'h2;
    sleep_go(1'b1, 2'h2);
    @(posedge sys_clk) wdt_rst <= 1'b1;
    @(posedge sys_clk) wdt_rst <= 1'b0;
    wake_seq(0, 1'b0, 1'b1, 1'b0);
    rd(3'h4, 8'h20);
    @(posedge sys_clk) fuses <= 2'h1;
  endtask
  task t_psave();
    wr(3'h2, 8'h08);
    wr(3'h3, 8'h01);
    for (int g = 1; g >= 0; g--) begin
      gie <= g[0];
      sleep_go(1'b1, 2'h3);
      chk("ps_state", {halt, osc_stop, t0_run}, 3'h7);
      @(posedge sys_clk) cmp_ev <= 1'b1;
      @(posedge sys_clk) cmp_ev <= 1'b0;
      repeat (20) tk();
      chk("ps_masked", osc_stop, 1'b1);
      @(posedge sys_clk) ovf_ev <= 1'b1;
      @(posedge sys_clk) ovf_ev <= 1'b0;
      wake_seq(3, g[0], 1'b0, 1'b0);
    end
    sleep_go(1'b1, 2'h3);
    @(posedge sys_clk) lvl_req <= 1'b1;
    wake_seq(2, 1'b1, 1'b0, 1'b1);
  endtask
  task t_reset_asleep();
    sleep_go(1'b1, 2'h2);
    @(posedge sys_clk) reset_n <= 1'b0;
    tk();
    chk("rst_wake", {halt, osc_stop}, 2'h0);
    @(posedge sys_clk) reset_n <= 1'b1;
    tk();
    chk("rst_release", {halt, t0_run}, 2'h1);
    rd(3'h0, 8'h00);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {reset_n, wr_en, rd_en, sleep_in, irq_pend, gie, wdt_rst, lvl_req, ovf_ev, cmp_ev} = '0;
    addr = 3'h0;
    wdata = 8'h00;
    clk_en = 1'b1;
    fuses = 2'h1;
    failures = 0;
    n_checks = 0;
    cycles = 0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs();
    t_refused();
    t_idle();
    t_pdown();
    t_psave();
    t_reset_asleep();
    stop_test();
  end
endmodule // tb
`default_nettype wire
